// *** dpac_defines.svh ***
// Notes on behaviour
// - each wiper setting register has a preload register, writable and readable back.
// - transfer command copies preload into wiper setting, one channel or all at once.
// - any new wiper setting value is also written into its preload register.
// - gain mode adds a second preload and wiper setting; switching keeps contents.
// - independent mode pin high at power-up starts gain mode, loading from memory.
// - effective mode is pin OR gain mode control bit; potentiometer only when both low.
// - entering top or bottom scale leaves wiper setting contents unchanged.
// - scale positions exit on exit command, any wiper load, or shutdown entry.
// - top scale: pot mode A-wiper top-scale, wiper-B end-to-end; gain mode both end-to-end.
// - bottom scale: wiper-B bottom-scale; A-wiper end-to-end pot, top-scale gain mode.
// - linear increment and decrement step one position, single or all channels.
// - plus 6 dB shifts left doubling, minus 6 dB shifts right halving.
// - left shift of zero gives one, of 0x80 gives full scale.
// - right shift inserts zero at top; one goes to zero, zero stays zero.
// - software reset and reset pin low pulse reload wipers from memory, about 30 us.
// - nonvolatile memory defaults to midscale so first power-up is midscale.
// - shutdown command enters on data bit 0 high, exits on low; contents kept.
// - every command is still accepted and executed while in shutdown.
// - shutdown path states depend on string select address bit and mode.
// - control bits 0 and 1 separately block memory and wiper setting updates.
// - protected wiper settings accept only the copy from nonvolatile memory.
`ifndef DPAC_DEFINES_SVH
`define DPAC_DEFINES_SVH

// ----------------------------------------
// command opcodes
// ----------------------------------------
`define DPAC_OP_NOP      4'h0
`define DPAC_OP_WR_WIPER 4'h1
`define DPAC_OP_WR_PRE   4'h2
`define DPAC_OP_READ     4'h3
`define DPAC_OP_LIN      4'h4
`define DPAC_OP_DB       4'h5
`define DPAC_OP_XFER     4'h6
`define DPAC_OP_COPY     4'h7
`define DPAC_OP_WR_NV    4'h8
`define DPAC_OP_SCALE    4'h9
`define DPAC_OP_SRESET   4'hB
`define DPAC_OP_SHUT     4'hC
`define DPAC_OP_CTRL     4'hD

// ----------------------------------------
// field positions and values
// ----------------------------------------
`define DPAC_A_ALL       3
`define DPAC_A_STR       2
`define DPAC_A_CH        0
`define DPAC_D_LSB       0
`define DPAC_D_TOP       7
`define DPAC_CB_NV_PROT  0
`define DPAC_CB_WP_PROT  1
`define DPAC_CB_GAIN     2
`define DPAC_CTRL_W      3
`define DPAC_CTRL_RST    3'h0
`define DPAC_RB_PRE      2'h0
`define DPAC_RB_NV       2'h1
`define DPAC_RB_CTRL     2'h2
`define DPAC_MIDSCALE    8'h80
`define DPAC_ZERO        8'h00
`define DPAC_ONE         8'h01
`define DPAC_FULL        8'hFF

// ----------------------------------------
// timing
// ----------------------------------------
`define DPAC_CLK_NS      20
`define DPAC_RELOAD_NS   30000
`define DPAC_RELOAD_CYC  (`DPAC_RELOAD_NS / `DPAC_CLK_NS)
`define DPAC_CNT_W       11

`endif

// *** dpac_pkg.sv ***
package dpac_pkg;

    // ----------------------------------------
    // command word and path state
    // ----------------------------------------
    typedef struct packed {
        logic [3:0] op;
        logic [3:0] addr;
        logic [7:0] data;
    } dpac_cmd_t;

    typedef enum logic [2:0] {
        PSEL_SETTING,
        PSEL_OPEN,
        PSEL_END,
        PSEL_TOP,
        PSEL_BOTTOM
    } dpac_psel_t;

    typedef struct packed {
        dpac_psel_t sel;
        logic [7:0] code;
    } dpac_path_t;

    typedef enum logic [2:0] {
        STEP_INC,
        STEP_DEC,
        STEP_SHL,
        STEP_SHR
    } dpac_step_t;

    typedef enum logic {
        ST_RELOAD,
        ST_RUN
    } dpac_state_t;

endpackage

// *** dpac_step.sv ***
`include "dpac_defines.svh"

module dpac_step
    import dpac_pkg::*;
(
    input  wire logic [7:0]         value,
    input  dpac_pkg::dpac_step_t    op,
    output logic [7:0]              result
);
    import dpac_pkg::*;

    // ----------------------------------------
    // step arithmetic
    // ----------------------------------------
    always_comb begin
        result = value;
        unique case (op)
            STEP_INC: result = (value == `DPAC_FULL) ? value : value + `DPAC_ONE;
            STEP_DEC: result = (value == `DPAC_ZERO) ? value : value - `DPAC_ONE;
            STEP_SHL: begin
                if (value == `DPAC_ZERO)
                    result = `DPAC_ONE;
                else if (value[7])
                    result = `DPAC_FULL;
                else
                    result = {value[6:0], 1'b0};
            end
            STEP_SHR: result = {1'b0, value[7:1]};
            default:  result = value;
        endcase
    end

endmodule // dpac_step

// *** dpac_core.sv ***
`include "dpac_defines.svh"

module dpac_core
    import dpac_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   cmd_valid,
    input  dpac_pkg::dpac_cmd_t         cmd,
    output logic                        cmd_ready,
    input  wire logic                   independent_mode_pin,
    input  wire logic                   reset_pin_n,
    output logic                        rd_valid,
    output logic [7:0]                  rd_data,
    output logic                        gain_mode,
    output logic [1:0]                  shutdown,
    output logic [1:0]                  top_scale_position,
    output logic [1:0]                  bottom_scale_position,
    output logic [1:0][1:0][7:0]        wiper_setting_register,
    output dpac_pkg::dpac_path_t [1:0]  a_to_wiper_resistance,
    output dpac_pkg::dpac_path_t [1:0]  wiper_to_b_resistance
);
    import dpac_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic               independent_mode_pin_m_r;
    logic               independent_mode_pin_s_r;
    logic               rpin_m_r;
    logic               rpin_s_r;
    logic               rpin_d_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            independent_mode_pin_m_r <= 1'b0;
            independent_mode_pin_s_r <= 1'b0;
            rpin_m_r  <= 1'b1;
            rpin_s_r  <= 1'b1;
            rpin_d_r  <= 1'b1;
        end else begin
            independent_mode_pin_m_r <= independent_mode_pin;
            independent_mode_pin_s_r <= independent_mode_pin_m_r;
            rpin_m_r  <= reset_pin_n;
            rpin_s_r  <= rpin_m_r;
            rpin_d_r  <= rpin_s_r;
        end
    end

    wire                rpin_fall = rpin_d_r & ~rpin_s_r;

    // ----------------------------------------
    // control register and mode
    // ----------------------------------------
    logic [`DPAC_CTRL_W-1:0] ctrl_r;
    wire                nv_prot = ctrl_r[`DPAC_CB_NV_PROT];
    wire                wp_prot = ctrl_r[`DPAC_CB_WP_PROT];
    wire                mode_lin = independent_mode_pin_s_r | ctrl_r[`DPAC_CB_GAIN];

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    dpac_state_t        state_r;
    logic [`DPAC_CNT_W-1:0] cnt_r;

    wire                go       = cmd_valid & cmd_ready;
    wire                d0       = cmd.data[`DPAC_D_LSB];
    wire                is_wr    = go & (cmd.op == `DPAC_OP_WR_WIPER);
    wire                is_pre   = go & (cmd.op == `DPAC_OP_WR_PRE);
    wire                is_rd    = go & (cmd.op == `DPAC_OP_READ);
    wire                is_lin   = go & (cmd.op == `DPAC_OP_LIN);
    wire                is_db    = go & (cmd.op == `DPAC_OP_DB);
    wire                is_xfer  = go & (cmd.op == `DPAC_OP_XFER);
    wire                is_to_nv = go & (cmd.op == `DPAC_OP_COPY) & d0;
    wire                is_fr_nv = go & (cmd.op == `DPAC_OP_COPY) & ~d0;
    wire                is_nv_wr = go & (cmd.op == `DPAC_OP_WR_NV);
    wire                is_scale = go & (cmd.op == `DPAC_OP_SCALE);
    wire                is_sres  = go & (cmd.op == `DPAC_OP_SRESET);
    wire                is_shut  = go & (cmd.op == `DPAC_OP_SHUT);
    wire                is_ctrl  = go & (cmd.op == `DPAC_OP_CTRL);
    wire                is_step  = is_lin | is_db;
    wire                all_ok   = is_step | is_xfer | is_scale | is_shut;
    wire                all_ch   = all_ok & cmd.addr[`DPAC_A_ALL];
    wire                str_sel  = mode_lin & cmd.addr[`DPAC_A_STR];
    wire                ch_addr  = cmd.addr[`DPAC_A_CH];
    wire                top_sel  = cmd.data[`DPAC_D_TOP];

    dpac_step_t         step_op;
    assign step_op = is_lin ? (d0 ? STEP_INC : STEP_DEC)
                            : (d0 ? STEP_SHL : STEP_SHR);

    // ----------------------------------------
    // reload sequencer
    // ----------------------------------------
    wire                reload_go   = is_sres | rpin_fall;
    wire                reload_done = (state_r == ST_RELOAD) &
                                      (cnt_r == `DPAC_CNT_W'(`DPAC_RELOAD_CYC - 1));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_RELOAD;
            cnt_r   <= '0;
        end else if (reload_go) begin
            state_r <= ST_RELOAD;
            cnt_r   <= '0;
        end else if (reload_done) begin
            state_r <= ST_RUN;
            cnt_r   <= '0;
        end else if (state_r == ST_RELOAD) begin
            cnt_r   <= cnt_r + `DPAC_CNT_W'(1);
        end
    end

    assign cmd_ready = (state_r == ST_RUN);

    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            ctrl_r <= `DPAC_CTRL_RST;
        else if (is_ctrl)
            ctrl_r <= cmd.data[`DPAC_CTRL_W-1:0];
    end

    // ----------------------------------------
    // per entry storage: channel by string
    // ----------------------------------------
    logic [1:0][1:0][7:0] pre_w;
    logic [1:0][1:0][7:0] nv_w;
    logic [1:0]           ch_load;

    genvar gc;
    genvar gs;
    generate
        for (gc = 0; gc < 2; gc++) begin : g_ch
            wire ch_hit = all_ch | (ch_addr == gc[0]);
            logic [1:0] load_s;
            for (gs = 0; gs < 2; gs++) begin : g_str
                logic [7:0] wip_r;
                logic [7:0] pre_r;
                logic [7:0] nv_r;
                logic [7:0] step_val;
                logic [7:0] wip_nxt;
                wire        hit     = ch_hit & (str_sel == gs[0]);
                wire        upd     = hit & ~wp_prot & (is_wr | is_step | is_xfer);
                wire        from_nv = reload_done | (hit & is_fr_nv);
                wire        load    = upd | from_nv;

                dpac_step u_step (
                    .value  (wip_r),
                    .op     (step_op),
                    .result (step_val)
                );

                assign wip_nxt = from_nv ? nv_r :
                                 is_wr   ? cmd.data :
                                 is_xfer ? pre_r : step_val;

                always_ff @(posedge clk or posedge reset) begin
                    if (reset) begin
                        wip_r <= `DPAC_MIDSCALE;
                        pre_r <= `DPAC_MIDSCALE;
                        nv_r  <= `DPAC_MIDSCALE;
                    end else begin
                        if (load) begin
                            wip_r <= wip_nxt;
                            pre_r <= wip_nxt;
                        end else if (hit & is_pre) begin
                            pre_r <= cmd.data;
                        end
                        if (hit & ~nv_prot & is_nv_wr)
                            nv_r <= cmd.data;
                        else if (hit & ~nv_prot & is_to_nv)
                            nv_r <= wip_r;
                    end
                end

                assign load_s[gs]                    = load;
                assign wiper_setting_register[gc][gs] = wip_r;
                assign pre_w[gc][gs]                 = pre_r;
                assign nv_w[gc][gs]                  = nv_r;
            end
            assign ch_load[gc] = |load_s;
        end
    endgenerate

    // ----------------------------------------
    // scale and shutdown state per channel
    // ----------------------------------------
    logic [1:0] ts_r;
    logic [1:0] bs_r;
    logic [1:0] sd_r;
    logic [1:0] sd_str_r;

    generate
        for (gc = 0; gc < 2; gc++) begin : g_state
            wire hit      = all_ch | (ch_addr == gc[0]);
            wire sd_enter = is_shut & hit & d0;
            wire ts_exit  = ch_load[gc] | sd_enter | (is_scale & hit & top_sel & ~d0);
            wire bs_exit  = ch_load[gc] | sd_enter | (is_scale & hit & ~top_sel & ~d0);
            wire ts_enter = is_scale & hit & top_sel & d0;
            wire bs_enter = is_scale & hit & ~top_sel & d0;

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    ts_r[gc]     <= 1'b0;
                    bs_r[gc]     <= 1'b0;
                    sd_r[gc]     <= 1'b0;
                    sd_str_r[gc] <= 1'b0;
                end else begin
                    if (ts_exit)
                        ts_r[gc] <= 1'b0;
                    else if (ts_enter)
                        ts_r[gc] <= 1'b1;
                    else if (bs_enter)
                        ts_r[gc] <= 1'b0;
                    if (bs_exit)
                        bs_r[gc] <= 1'b0;
                    else if (bs_enter)
                        bs_r[gc] <= 1'b1;
                    else if (ts_enter)
                        bs_r[gc] <= 1'b0;
                    if (reload_done) begin
                        sd_r[gc] <= 1'b0;
                    end else if (is_shut & hit) begin
                        sd_r[gc]     <= d0;
                        sd_str_r[gc] <= cmd.addr[`DPAC_A_STR];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // resistance path selection
    // ----------------------------------------
    dpac_path_t [1:0] aw_nxt;
    dpac_path_t [1:0] wb_nxt;

    generate
        for (gc = 0; gc < 2; gc++) begin : g_path
            wire [7:0] s0 = wiper_setting_register[gc][0];
            wire [7:0] s1 = wiper_setting_register[gc][1];
            always_comb begin
                aw_nxt[gc] = mode_lin ? dpac_path_t'{PSEL_SETTING, s1}
                                      : dpac_path_t'{PSEL_SETTING, ~s0};
                wb_nxt[gc] = '{PSEL_SETTING, s0};
                if (sd_r[gc]) begin
                    if (!mode_lin) begin
                        aw_nxt[gc] = '{PSEL_OPEN, `DPAC_ZERO};
                        wb_nxt[gc] = '{PSEL_BOTTOM, `DPAC_ZERO};
                    end else if (sd_str_r[gc]) begin
                        aw_nxt[gc] = '{PSEL_OPEN, `DPAC_ZERO};
                    end else begin
                        wb_nxt[gc] = '{PSEL_OPEN, `DPAC_ZERO};
                    end
                end else if (ts_r[gc]) begin
                    aw_nxt[gc] = mode_lin ? dpac_path_t'{PSEL_END, `DPAC_ZERO}
                                          : dpac_path_t'{PSEL_TOP, `DPAC_ZERO};
                    wb_nxt[gc] = '{PSEL_END, `DPAC_ZERO};
                end else if (bs_r[gc]) begin
                    aw_nxt[gc] = mode_lin ? dpac_path_t'{PSEL_TOP, `DPAC_ZERO}
                                          : dpac_path_t'{PSEL_END, `DPAC_ZERO};
                    wb_nxt[gc] = '{PSEL_BOTTOM, `DPAC_ZERO};
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            a_to_wiper_resistance <= '{2{'{PSEL_SETTING, `DPAC_MIDSCALE}}};
            wiper_to_b_resistance <= '{2{'{PSEL_SETTING, `DPAC_MIDSCALE}}};
        end else begin
            a_to_wiper_resistance <= aw_nxt;
            wiper_to_b_resistance <= wb_nxt;
        end
    end

    // ----------------------------------------
    // readback
    // ----------------------------------------
    wire [1:0] rb_src = cmd.data[1:0];
    wire       rb_str = cmd.addr[`DPAC_A_STR];
    wire [7:0] rb_val = (rb_src == `DPAC_RB_PRE)  ? pre_w[ch_addr][rb_str] :
                        (rb_src == `DPAC_RB_NV)   ? nv_w[ch_addr][rb_str] :
                        (rb_src == `DPAC_RB_CTRL) ? {5'h00, ctrl_r} :
                        wiper_setting_register[ch_addr][rb_str];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_valid <= 1'b0;
            rd_data  <= `DPAC_ZERO;
        end else begin
            rd_valid <= is_rd;
            if (is_rd)
                rd_data <= rb_val;
        end
    end

    // ----------------------------------------
    // status
    // ----------------------------------------
    assign gain_mode             = mode_lin;
    assign shutdown              = sd_r;
    assign top_scale_position    = ts_r;
    assign bottom_scale_position = bs_r;

endmodule // dpac_core

// *** dpac_host.sv ***
module dpac_host
    import dpac_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           cmd_ready,
    output logic                cmd_valid,
    output dpac_pkg::dpac_cmd_t cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    import dpac_pkg::*;
    // ----
    // host: wait for ready, then offer one word for one cycle
    // ----
    bit ok;
    initial begin
        cmd_valid = 1'b0;
        cmd = 16'hFFFF;
    end
    task automatic send(input logic [15:0] w);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        ok = (n < 2000);
        cmd_valid = 1'b1;
        cmd = w;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        cmd = ~w;
        @(posedge clk);
        #1;
    endtask
endmodule // dpac_host

// *** dpac_core_properties.sv ***
module dpac_props
    import dpac_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  cmd_valid,
    input  dpac_pkg::dpac_cmd_t        cmd,
    input  wire logic                  cmd_ready,
    input  wire logic                  rd_valid,
    input  wire logic                  gain_mode,
    input  wire logic [1:0]            shutdown,
    input  wire logic [1:0]            top_scale_position,
    input  wire logic [1:0]            bottom_scale_position,
    input  wire logic [1:0][1:0][7:0]  wiper_setting_register,
    input  dpac_pkg::dpac_path_t [1:0] a_to_wiper_resistance,
    input  dpac_pkg::dpac_path_t [1:0] wiper_to_b_resistance
);
    timeunit 1ns;
    timeprecision 1ps;
    import dpac_pkg::*;
    // ----
    // helpers
    // ----
    wire logic tk = cmd_valid && cmd_ready;
    wire logic rdtk = tk && cmd.op == 4'h3;
    wire logic w1 = tk && cmd.op == 4'h1;
    wire logic pot = !gain_mode;
    logic wp_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) wp_r <= 1'b0;
        else if (tk && cmd.op == 4'hD) wp_r <= cmd.data[1];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ----
    // properties
    // ----
    property p_rd; rdtk |=> rd_valid; endproperty
    a_rd: assert property (p_rd) else $error("no read pulse");
    property p_rdonly; rd_valid |-> $past(rdtk); endproperty
    a_rdonly: assert property (p_rdonly) else $error("stray read pulse");
    property p_gain; tk && cmd.op == 4'hD && cmd.data[2] |=> gain_mode; endproperty
    a_gain: assert property (p_gain) else $error("gain mode not set");
    property p_top;
        tk && cmd.op == 4'h9 && cmd.addr == 4'h0 && cmd.data == 8'h81
            |=> $stable(wiper_setting_register) && top_scale_position[0];
    endproperty
    a_top: assert property (p_top) else $error("top scale entry wrong");
    property p_shut;
        tk && cmd.op == 4'hC && cmd.addr[3] && cmd.data[0]
            |=> shutdown == 2'b11 && top_scale_position == 2'b00
                && bottom_scale_position == 2'b00;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown entry wrong");
    property p_wp; w1 && wp_r |=> $stable(wiper_setting_register); endproperty
    a_wp: assert property (p_wp) else $error("protected write landed");
    property p_wr;
        w1 && !wp_r && pot && cmd.addr == 4'h0
            |=> wiper_setting_register[0][0] == $past(cmd.data);
    endproperty
    a_wr: assert property (p_wr) else $error("wiper write lost");
    property p_inc;
        tk && cmd.op == 4'h4 && cmd.data[0] && cmd.addr == 4'h0 && !wp_r && pot
            |=> wiper_setting_register[0][0] ==
                ($past(wiper_setting_register[0][0]) == 8'hFF ? 8'hFF
                 : $past(wiper_setting_register[0][0]) + 8'h01);
    endproperty
    a_inc: assert property (p_inc) else $error("increment wrong");
    property p_rdy; tk && cmd.op == 4'hB |=> !cmd_ready [*8]; endproperty
    a_rdy: assert property (p_rdy) else $error("reload not busy");
    property p_sdp;
        shutdown[0] && pot ##1 shutdown[0] && pot
            |-> a_to_wiper_resistance[0].sel == PSEL_OPEN
                && wiper_to_b_resistance[0].sel == PSEL_BOTTOM;
    endproperty
    a_sdp: assert property (p_sdp) else $error("shutdown path wrong");
    property p_tsp;
        (top_scale_position[0] && !shutdown[0] && pot) [*2]
            |-> a_to_wiper_resistance[0].sel == PSEL_TOP
                && wiper_to_b_resistance[0].sel == PSEL_END;
    endproperty
    a_tsp: assert property (p_tsp) else $error("top path wrong");
    c_rd: cover property (rdtk);
    c_sd: cover property (shutdown[0] && pot ##1 shutdown[0]);
    c_rl: cover property (tk && cmd.op == 4'hB);
endmodule // dpac_props
bind dpac_core dpac_props u_props (.clk, .reset, .cmd_valid, .cmd, .cmd_ready, .rd_valid,
    .gain_mode, .shutdown, .top_scale_position, .bottom_scale_position,
    .wiper_setting_register, .a_to_wiper_resistance, .wiper_to_b_resistance);

// *** digipot_advanced_control_tb.sv ***
module digipot_advanced_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dpac_pkg::*;
    // ----
    // signals
    // ----
    typedef struct packed {
        logic [15:0] c;
        logic [7:0]  e0;
        logic [7:0]  e1;
    } dpac_row_t;
    logic clk, reset, cmd_valid, cmd_ready, independent_mode_pin, reset_pin_n;
    logic rd_valid, gain_mode;
    logic [7:0] rd_data;
    logic [1:0] shutdown, top_scale_position, bottom_scale_position;
    logic [1:0][1:0][7:0] wiper_setting_register;
    dpac_cmd_t cmd;
    dpac_path_t [1:0] a_to_wiper_resistance, wiper_to_b_resistance;
    int error_cnt = 0;
    int check_count = 0;
    wire logic [7:0] w0 = wiper_setting_register[0][0];
    wire logic [7:0] w1 = wiper_setting_register[1][0];
    dpac_row_t rows[15] = '{
        '{16'h1040, 8'h40, 8'h80}, '{16'h2111, 8'h40, 8'h80}, '{16'h6800, 8'h40, 8'h11},
        '{16'h4001, 8'h41, 8'h11}, '{16'h4800, 8'h40, 8'h10}, '{16'h1100, 8'h40, 8'h00},
        '{16'h4100, 8'h40, 8'h00}, '{16'h5101, 8'h40, 8'h01}, '{16'h1080, 8'h80, 8'h01},
        '{16'h5001, 8'hFF, 8'h01}, '{16'h4001, 8'hFF, 8'h01}, '{16'h5000, 8'h7F, 8'h01},
        '{16'h5100, 8'h7F, 8'h00}, '{16'h5100, 8'h7F, 8'h00}, '{16'h10C3, 8'hC3, 8'h00}};
    dpac_core uut (.clk, .reset, .cmd_valid, .cmd, .cmd_ready, .independent_mode_pin,
        .reset_pin_n, .rd_valid, .rd_data, .gain_mode, .shutdown, .top_scale_position,
        .bottom_scale_position, .wiper_setting_register, .a_to_wiper_resistance,
        .wiper_to_b_resistance);
    dpac_host h (.clk, .cmd_ready, .cmd_valid, .cmd);
    // ----
    // tasks
    // ----
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic c8(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic c1(input string n, input logic e, input logic g);
        c8(n, {7'h00, e}, {7'h00, g});
    endtask
    task automatic s(input logic [15:0] w);
        h.send(w);
        if (!h.ok) begin
            error_cnt++;
            tally_and_finish;
        end
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // ----
    // stimulus
    // ----
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        reset = 1'b1;
        independent_mode_pin = 1'b0;
        reset_pin_n = 1'b1;
        pause(3);
        reset = 1'b0;
        c8("mid0", 8'h80, w0);
        c8("mid1", 8'h80, w1);
        foreach (rows[i]) begin
            s(rows[i].c);
            c8("row w0", rows[i].e0, w0);
            c8("row w1", rows[i].e1, w1);
        end
        s(16'h3100);
        c8("pre1", 8'h00, rd_data);
        repeat (10) s(16'h5101);
        c8("ten up", 8'hFF, w1);
        s(16'h9081);
        c1("top", 1'b1, top_scale_position[0]);
        c8("top w", 8'hC3, w0);
        c1("aw top", 1'b1, a_to_wiper_resistance[0].sel === PSEL_TOP);
        c1("wb end", 1'b1, wiper_to_b_resistance[0].sel === PSEL_END);
        s(16'h4001);
        c1("top out", 1'b0, top_scale_position[0]);
        s(16'h9001);
        c1("bot", 1'b1, bottom_scale_position[0]);
        c1("wb bot", 1'b1, wiper_to_b_resistance[0].sel === PSEL_BOTTOM);
        c1("aw end", 1'b1, a_to_wiper_resistance[0].sel === PSEL_END);
        s(16'hC801);
        c1("bot out", 1'b0, bottom_scale_position[0]);
        c1("sd", 1'b1, shutdown[0]);
        c8("sd w", 8'hC4, w0);
        c1("aw open", 1'b1, a_to_wiper_resistance[0].sel === PSEL_OPEN);
        s(16'h1022);
        c8("sd wr", 8'h22, w0);
        s(16'hC800);
        c1("sd out", 1'b0, shutdown[0]);
        s(16'hD002);
        s(16'h1055);
        c8("wp", 8'h22, w0);
        s(16'h7000);
        c8("nv copy", 8'h80, w0);
        s(16'hD001);
        s(16'h8033);
        s(16'h3001);
        c8("nvp", 8'h80, rd_data);
        s(16'hD000);
        s(16'h8033);
        s(16'h3001);
        c8("nv", 8'h33, rd_data);
        s(16'h7101);
        s(16'h3101);
        c8("nv copy1", 8'hFF, rd_data);
        s(16'hD004);
        c1("gm", 1'b1, gain_mode);
        c8("gm keep", 8'h80, w0);
        s(16'h1466);
        c8("str1", 8'h66, wiper_setting_register[0][1]);
        c8("str0", 8'h80, w0);
        s(16'h9081);
        c1("gm aw top", 1'b1, a_to_wiper_resistance[0].sel === PSEL_END);
        c1("gm wb top", 1'b1, wiper_to_b_resistance[0].sel === PSEL_END);
        s(16'h9080);
        c1("top exit", 1'b0, top_scale_position[0]);
        s(16'h9001);
        c1("gm aw bot", 1'b1, a_to_wiper_resistance[0].sel === PSEL_TOP);
        s(16'hC001);
        c1("gm wb sd", 1'b1, wiper_to_b_resistance[0].sel === PSEL_OPEN);
        s(16'hC401);
        c1("gm aw sd", 1'b1, a_to_wiper_resistance[0].sel === PSEL_OPEN);
        s(16'hC000);
        s(16'h3002);
        c8("rb ctrl", 8'h04, rd_data);
        s(16'h3403);
        c8("rb str1", 8'h66, rd_data);
        s(16'hD000);
        c1("pot", 1'b0, gain_mode);
        independent_mode_pin = 1'b1;
        pause(4);
        c1("pin gm", 1'b1, gain_mode);
        independent_mode_pin = 1'b0;
        s(16'hB000);
        c1("busy", 1'b0, cmd_ready);
        s(16'h0000);
        c8("srst", 8'h33, w0);
        s(16'h1010);
        reset_pin_n = 1'b0;
        pause(8);
        reset_pin_n = 1'b1;
        s(16'h0000);
        c8("pin rst", 8'h33, w0);
        independent_mode_pin = 1'b1;
        reset = 1'b1;
        pause(3);
        reset = 1'b0;
        s(16'h0000);
        c1("pwr gm", 1'b1, gain_mode);
        c8("pwr s1", 8'h80, wiper_setting_register[0][1]);
        tally_and_finish;
    end
endmodule // digipot_advanced_control_tb
